// ==== hdl/wha_map.svh ====
`ifndef WHA_MAP_SVH
`define WHA_MAP_SVH

// system register encoding keys shared by all five registers
`define WHA_KEY_OP0        2'h3
`define WHA_KEY_CRN        4'hf
// walk hint control register key
`define WHA_CTRL_OP1       3'h4
`define WHA_CTRL_CRM       4'h7
`define WHA_CTRL_OP2       3'h1
// power and performance register keys
`define WHA_PPM_OP1        3'h6
`define WHA_PPM_CRM        4'h2
`define WHA_PPM_A_OP2      3'h0
`define WHA_PPM_B_OP2      3'h1
`define WHA_PPM_D_OP2      3'h4
`define WHA_PPM_E_OP2      3'h5

// field positions of the walk hint control register
`define WHA_B0_EN_LSB      0
`define WHA_VS_EN_LSB      4
`define WHA_B0_VAL_LSB     8
`define WHA_VS_VAL_LSB     12
`define WHA_CTRL_WIDTH     16
`define WHA_REG_WIDTH      64

// reset values
`define WHA_CTRL_RESET     16'h0000
`define WHA_PPM_RESET      64'h0000_0000_0000_0000

// exception levels and trap syndrome
`define WHA_EL0            2'h0
`define WHA_EL1            2'h1
`define WHA_EL2            2'h2
`define WHA_EL3            2'h3
`define WHA_TRAP_CLASS     6'h18

`endif

// ==== hdl/wha_pkg.sv ====
package wha_pkg;

    typedef enum logic [1:0] {
        ACC_OK,
        ACC_UNDEF,
        ACC_TRAP
    } wha_outcome_t;

    typedef enum logic [1:0] {
        WALK_OTHER,
        WALK_VS2,
        WALK_B0
    } wha_walk_t;

endpackage : wha_pkg

// ==== hdl/wha_hint_gate.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "wha_map.svh"

module wha_hint_gate #(
    parameter int HINT_W = 4
) (
    // control fields
    input  wire logic [`WHA_CTRL_WIDTH-1:0] ctrl,
    // walk base in use
    input  wire wha_pkg::wha_walk_t        walkSel,
    // gated hint
    output logic      [HINT_W-1:0]         hint
);

    always_comb begin
        unique case (walkSel)
            wha_pkg::WALK_VS2: begin
                // value only passes where its enable is set
                hint = ctrl[`WHA_VS_VAL_LSB +: HINT_W] & ctrl[`WHA_VS_EN_LSB +: HINT_W];
            end
            wha_pkg::WALK_B0: begin
                hint = ctrl[`WHA_B0_VAL_LSB +: HINT_W] & ctrl[`WHA_B0_EN_LSB +: HINT_W];
            end
            wha_pkg::WALK_OTHER: begin
                hint = '0;
            end
            default: begin
                hint = '0;
            end
        endcase
    end

endmodule : wha_hint_gate
`default_nettype wire

// ==== hdl/wha_walk_hint_control.sv ====
// Summary of operation
// - Walks through the secure virtual stage-2 base take hints 0-3 from bits 12-15 when enabled.
// - Bits 4-7 enable hints 0-3 for walks through the secure virtual stage-2 base.
// - A hint whose enable is clear is driven as zero whatever its value bit holds.
// - Walks through the EL2 translation base 0 take hints 0-3 from bits 8-11 when enabled.
// - Bits 0-3 enable hints 0-3 for walks through the EL2 translation base 0.
// - Any access to these registers at EL0 is undefined.
// - At EL1 the hint register traps to EL2 with class 0x18 under EL2 and nesting, else undefined.
// - At EL2 and EL3 the hint register is read and written without a trap.
// - The four power and performance registers are reachable only at EL3, undefined at EL1/EL2.
// - All 64 bits of each power and performance register are reserved, with no function.
// - Each of the five registers is 64 bits wide and always present.
`timescale 1ns/1ns
`default_nettype none
`include "wha_map.svh"

module wha_walk_hint_control #(
    parameter int HINT_W  = 4,
    parameter int PPM_NUM = 4
) (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rstn,
    input  wire logic                      clkEn,
    // system register access
    input  wire logic                      accValid,
    input  wire logic                      accWrite,
    input  wire logic [1:0]                accOp0,
    input  wire logic [2:0]                accOp1,
    input  wire logic [3:0]                accCrn,
    input  wire logic [3:0]                accCrm,
    input  wire logic [2:0]                accOp2,
    input  wire logic [`WHA_REG_WIDTH-1:0] accWdata,
    // processor state
    input  wire logic [1:0]                excLevel,
    input  wire logic                      el2Enabled,
    input  wire logic                      nestedVirtFlag,
    // access answer
    output logic                           rspValid,
    output logic                           rspUndef,
    output logic                           rspTrap,
    output logic [5:0]                     rspSyndrome,
    output logic [`WHA_REG_WIDTH-1:0]      rspRdata,
    // table walker
    input  wire logic                      walkValid,
    input  wire wha_pkg::wha_walk_t        walkSel,
    output logic                           walkHintValid,
    output logic [HINT_W-1:0]              walkHint
);

    function automatic logic keyMatch(input logic [2:0] op1, input logic [3:0] crm,
                                      input logic [2:0] op2);
        keyMatch = (accOp0 == `WHA_KEY_OP0) && (accCrn == `WHA_KEY_CRN) &&
                   (accOp1 == op1) && (accCrm == crm) && (accOp2 == op2);
    endfunction : keyMatch

    logic [`WHA_CTRL_WIDTH-1:0] ctrl;
    logic [`WHA_REG_WIDTH-1:0]  ppm [PPM_NUM];
    logic [HINT_W-1:0]          next_hint;
    logic                       hitCtrl;
    logic                       hitPpm;
    logic [1:0]                 ppmIdx;
    wha_pkg::wha_outcome_t      outcome;
    logic                       doAcc;

    // ---- decode ----
    always_comb begin
        hitCtrl = keyMatch(`WHA_CTRL_OP1, `WHA_CTRL_CRM, `WHA_CTRL_OP2);
        hitPpm  = 1'b1;
        ppmIdx  = 2'h0;
        if (keyMatch(`WHA_PPM_OP1, `WHA_PPM_CRM, `WHA_PPM_A_OP2)) begin
            ppmIdx = 2'h0;
        end else if (keyMatch(`WHA_PPM_OP1, `WHA_PPM_CRM, `WHA_PPM_B_OP2)) begin
            ppmIdx = 2'h1;
        end else if (keyMatch(`WHA_PPM_OP1, `WHA_PPM_CRM, `WHA_PPM_D_OP2)) begin
            ppmIdx = 2'h2;
        end else if (keyMatch(`WHA_PPM_OP1, `WHA_PPM_CRM, `WHA_PPM_E_OP2)) begin
            ppmIdx = 2'h3;
        end else begin
            hitPpm = 1'b0;
        end
    end

    assign doAcc = accValid && (hitCtrl || hitPpm);

    // ---- privilege check ----
    always_comb begin
        outcome = wha_pkg::ACC_UNDEF;
        if (excLevel == `WHA_EL0) begin
            outcome = wha_pkg::ACC_UNDEF;
        end else if (hitCtrl) begin
            if (excLevel != `WHA_EL1) begin
                outcome = wha_pkg::ACC_OK;
            end else if (el2Enabled && nestedVirtFlag) begin
                outcome = wha_pkg::ACC_TRAP;
            end else begin
                outcome = wha_pkg::ACC_UNDEF;
            end
        end else if (excLevel == `WHA_EL3) begin
            outcome = wha_pkg::ACC_OK;
        end else begin
            outcome = wha_pkg::ACC_UNDEF;
        end
    end

    // ---- hint control storage ----
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `WHA_CTRL_RESET;
        end else if (clkEn && doAcc && hitCtrl && accWrite && outcome == wha_pkg::ACC_OK) begin
            // upper bits are simply not stored
            ctrl <= accWdata[`WHA_CTRL_WIDTH-1:0];
        end
    end

    // ---- reserved power/perf storage ----
    // kept as plain scratch so software reads back what it wrote; nothing else looks at it
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < PPM_NUM; i++) begin
                ppm[i] <= `WHA_PPM_RESET;
            end
        end else if (clkEn && doAcc && hitPpm && accWrite && outcome == wha_pkg::ACC_OK) begin
            ppm[ppmIdx] <= accWdata;
        end
    end

    // ---- access answer ----
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rspValid    <= 1'b0;
            rspUndef    <= 1'b0;
            rspTrap     <= 1'b0;
            rspSyndrome <= 6'h00;
            rspRdata    <= '0;
        end else if (clkEn) begin
            rspValid    <= doAcc;
            rspUndef    <= 1'b0;
            rspTrap     <= 1'b0;
            rspSyndrome <= 6'h00;
            rspRdata    <= '0;
            if (doAcc) begin
                unique case (outcome)
                    wha_pkg::ACC_OK: begin
                        if (!accWrite && hitCtrl) begin
                            // zero-extended, upper bits read zero
                            rspRdata <= {{(`WHA_REG_WIDTH-`WHA_CTRL_WIDTH){1'b0}}, ctrl};
                        end else if (!accWrite) begin
                            rspRdata <= ppm[ppmIdx];
                        end
                    end
                    wha_pkg::ACC_UNDEF: begin
                        rspUndef <= 1'b1;
                    end
                    wha_pkg::ACC_TRAP: begin
                        rspTrap     <= 1'b1;
                        rspSyndrome <= `WHA_TRAP_CLASS;
                    end
                endcase
            end
        end
    end

    // ---- walk hint path ----
    wha_hint_gate #(
        .HINT_W (HINT_W)
    ) u_gate (
        .ctrl    (ctrl),
        .walkSel (walkSel),
        .hint    (next_hint)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            walkHintValid <= 1'b0;
            walkHint      <= '0;
        end else if (clkEn) begin
            walkHintValid <= walkValid;
            // idle cycles show zero so a stale hint never leaks
            walkHint      <= walkValid ? next_hint : '0;
        end
    end

    // ---- checks ----
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);

    el0_undef_a: assert property (
        clkEn && doAcc && excLevel == `WHA_EL0 |=> rspValid && rspUndef && !rspTrap)
        else $error("access at EL0 not undefined");

    el1_trap_a: assert property (
        clkEn && doAcc && hitCtrl && excLevel == `WHA_EL1 && el2Enabled && nestedVirtFlag
        |=> rspTrap && rspSyndrome == 6'h18 && !rspUndef)
        else $error("EL1 nested access did not trap");

    el1_undef_a: assert property (
        clkEn && doAcc && hitCtrl && excLevel == `WHA_EL1 && !(el2Enabled && nestedVirtFlag)
        |=> rspUndef && !rspTrap)
        else $error("EL1 access without nesting not undefined");

    el2_free_a: assert property (
        clkEn && doAcc && hitCtrl && excLevel[1] |=> rspValid && !rspUndef && !rspTrap)
        else $error("EL2/EL3 hint register access refused");

    ppm_level_a: assert property (
        clkEn && doAcc && hitPpm && excLevel != `WHA_EL3 |=> rspUndef)
        else $error("power register reachable below EL3");

    ctrl_write_a: assert property (
        clkEn && doAcc && hitCtrl && accWrite && excLevel[1]
        |=> ctrl == $past(accWdata[`WHA_CTRL_WIDTH-1:0]))
        else $error("hint register write lost");

    upper_zero_a: assert property (
        clkEn && doAcc && hitCtrl && !accWrite && excLevel[1]
        |=> rspRdata[63:16] == 48'h0 && rspRdata[15:0] == $past(ctrl))
        else $error("hint register read wrong");

    ppm_echo_a: assert property (
        clkEn && doAcc && hitPpm && accWrite && excLevel == `WHA_EL3
        ##1 clkEn && accValid && !accWrite && hitPpm && excLevel == `WHA_EL3
            && ppmIdx == $past(ppmIdx)
        |=> rspRdata == $past(accWdata, 2))
        else $error("power register did not hold value");

    vs_hint_a: assert property (
        clkEn && walkValid && walkSel == wha_pkg::WALK_VS2
        |=> walkHintValid && walkHint == ($past(ctrl[15:12]) & $past(ctrl[7:4])))
        else $error("secure stage-2 walk hint wrong");

    b0_hint_a: assert property (
        clkEn && walkValid && walkSel == wha_pkg::WALK_B0
        |=> walkHint == ($past(ctrl[11:8]) & $past(ctrl[3:0])))
        else $error("base 0 walk hint wrong");

    hint_off_a: assert property (
        clkEn && walkValid && walkSel == wha_pkg::WALK_VS2 && ctrl[7:4] == 4'h0
        |=> walkHint == 4'h0)
        else $error("disabled hint driven");

    b0_off_a: assert property (
        clkEn && walkValid && walkSel == wha_pkg::WALK_B0 && ctrl[3:0] == 4'h0
        |=> walkHint == 4'h0)
        else $error("disabled base 0 hint driven");

    freeze_a: assert property (
        !clkEn |=> $stable(ctrl) && $stable(rspValid) && $stable(walkHint))
        else $error("state moved with clock enable low");

    // enabled cycles without a walk leave the hint valid and hint lines quiet
    idle_hint_a: assert property (
        clkEn && !walkValid |=> !walkHintValid && walkHint == 4'h0)
        else $error("hint driven without a walk");

    other_hint_a: assert property (
        clkEn && walkValid && walkSel == wha_pkg::WALK_OTHER
        |=> walkHintValid && walkHint == 4'h0)
        else $error("hint driven on an unhinted walk");

    vs_en_gate_a: assert property (
        clkEn && walkValid && walkSel == wha_pkg::WALK_VS2
        |=> (walkHint & ~$past(ctrl[7:4])) == 4'h0)
        else $error("secure stage-2 hint passed a clear enable");

    b0_en_gate_a: assert property (
        clkEn && walkValid && walkSel == wha_pkg::WALK_B0
        |=> (walkHint & ~$past(ctrl[3:0])) == 4'h0)
        else $error("base 0 hint passed a clear enable");

    quiet_miss_a: assert property (
        clkEn && !doAcc |=> !rspValid && !rspUndef && !rspTrap && rspRdata == 64'h0)
        else $error("answer without a matching access");

    answer_qual_a: assert property (
        !rspValid |-> !rspUndef && !rspTrap && rspSyndrome == 6'h00)
        else $error("answer flags raised without an answer");

    trap_syndrome_a: assert property (
        rspValid && !rspTrap |-> rspSyndrome == 6'h00)
        else $error("syndrome shown without a trap");

    one_outcome_a: assert property (
        rspValid |-> !(rspUndef && rspTrap))
        else $error("access both trapped and undefined");

    refused_write_a: assert property (
        clkEn && doAcc && hitCtrl && accWrite && !excLevel[1] |=> $stable(ctrl))
        else $error("hint register written below EL2");

    refused_read_a: assert property (
        clkEn && doAcc && !accWrite && outcome != wha_pkg::ACC_OK |=> rspRdata == 64'h0)
        else $error("refused read returned data");

    ppm_write_a: assert property (
        clkEn && doAcc && hitPpm && accWrite && excLevel == `WHA_EL3
        |=> ppm[$past(ppmIdx)] == $past(accWdata))
        else $error("power register write lost");

    ppm_guard_a: assert property (
        clkEn && doAcc && hitPpm && accWrite && excLevel != `WHA_EL3
        |=> ppm[$past(ppmIdx)] == $past(ppm[ppmIdx]))
        else $error("power register written below EL3");

    trap_seen_c: cover property (clkEn && doAcc && outcome == wha_pkg::ACC_TRAP);
    ctrl_wr_c:   cover property (clkEn && doAcc && hitCtrl && accWrite && excLevel[1]);
    vs_hint_c:   cover property (walkHintValid && walkHint != 4'h0);
    ppm_wr_c:    cover property (clkEn && doAcc && hitPpm && excLevel == `WHA_EL3);
    freeze_c:    cover property (!clkEn && accValid);

endmodule : wha_walk_hint_control
`default_nettype wire

// ==== dv/wha_walker_model.sv ====
`timescale 1ns/1ns
`default_nettype none

module wha_walker_model (
    // clock and reset
    input  wire logic          clock,
    input  wire logic          rstn,
    // walks toward the hint block
    output logic               walkValid,
    output wha_pkg::wha_walk_t walkSel
);
    integer seed = 98;
    integer r;

    // random gaps and bases, back to back walks included; sel is noise between walks
    always @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            walkValid <= 1'b0;
            walkSel   <= wha_pkg::WALK_OTHER;
        end else begin
            r = $random(seed);
            walkValid <= r[0] | r[1];
            walkSel   <= wha_pkg::wha_walk_t'(r[3:2] % 3);
        end
    end
endmodule : wha_walker_model
`default_nettype wire

// ==== dv/wha_walk_hint_control_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "wha_map.svh"

module wha_walk_hint_control_tb;
    logic               clock = 1'b0;
    logic               rstn = 1'b0;
    logic               clkEn = 1'b1;
    logic [3:0]         accCrn = `WHA_KEY_CRN;
    logic               accValid = 1'b0;
    logic               accWrite = 1'b0;
    logic [2:0]         accOp1 = 3'h0;
    logic [3:0]         accCrm = 4'h0;
    logic [2:0]         accOp2 = 3'h0;
    logic [63:0]        accWdata = 64'h0;
    logic [1:0]         excLevel = 2'h0;
    logic               el2Enabled = 1'b0;
    logic               nestedVirtFlag = 1'b0;
    logic               rspValid, rspUndef, rspTrap, walkValid, walkHintValid;
    logic [5:0]         rspSyndrome;
    logic [63:0]        rspRdata;
    logic [3:0]         walkHint;
    logic [3:0]         expHint = 4'h0;
    logic               expHintValid = 1'b0;
    wha_pkg::wha_walk_t walkSel;
    // entry 0 mirrors the hint register, 1..4 the power registers
    logic [63:0]        regM [0:4] = '{default: 64'h0};
    integer             seed = 98;
    integer             nErrors = 0;
    integer             checks = 0;

    always #25 clock = ~clock;

    wha_walker_model u_walker (.clock(clock), .rstn(rstn), .walkValid(walkValid),
                               .walkSel(walkSel));

    wha_walk_hint_control u_dut (
        .clock(clock), .rstn(rstn), .clkEn(clkEn), .accValid(accValid), .accWrite(accWrite),
        .accOp0(`WHA_KEY_OP0), .accOp1(accOp1), .accCrn(accCrn), .accCrm(accCrm),
        .accOp2(accOp2), .accWdata(accWdata), .excLevel(excLevel), .el2Enabled(el2Enabled),
        .nestedVirtFlag(nestedVirtFlag), .rspValid(rspValid), .rspUndef(rspUndef),
        .rspTrap(rspTrap), .rspSyndrome(rspSyndrome), .rspRdata(rspRdata),
        .walkValid(walkValid), .walkSel(walkSel), .walkHintValid(walkHintValid),
        .walkHint(walkHint));

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checks = checks + 1;
        if (got !== exp) begin
            nErrors = nErrors + 1;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic tallyAndFinish();
        $display("checks=%0d errors=%0d", checks, nErrors);
        if (nErrors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : tallyAndFinish

    // hint seen one edge after the walk, built from the register as it stood then
    always @(posedge clock) begin
        if (rstn) begin
            check({walkHintValid, walkHint}, {expHintValid, expHint});
        end
        // a frozen edge holds the previous hint
        if (clkEn) begin
            expHintValid <= walkValid & rstn;
            expHint      <= !walkValid ? 4'h0 :
                            (walkSel == wha_pkg::WALK_VS2) ? regM[0][15:12] & regM[0][7:4] :
                            (walkSel == wha_pkg::WALK_B0) ? regM[0][11:8] & regM[0][3:0] : 4'h0;
        end
    end

    // k: 0 hint register, 1..4 power registers, 5 an unmapped key
    task automatic acc(input int k, input logic wr, input logic [1:0] el, input logic e2,
                       input logic nv, input logic [63:0] wd);
        logic [2:0]  op2Tab [0:5];
        logic        ev, et, eu, ok;
        logic [63:0] er;
        op2Tab = '{`WHA_CTRL_OP2, `WHA_PPM_A_OP2, `WHA_PPM_B_OP2, `WHA_PPM_D_OP2,
                   `WHA_PPM_E_OP2, 3'h0};
        ev = (k != 5);
        et = (k == 0) && (el == `WHA_EL1) && e2 && nv;
        eu = (el == `WHA_EL0) || ((k == 0) ? (el == `WHA_EL1) && !et : (el != `WHA_EL3));
        ok = ev && !eu && !et;
        er = (ok && !wr) ? regM[k] : 64'h0;
        @(posedge clock);
        accValid       <= 1'b1;
        accWrite       <= wr;
        accOp1         <= (k == 0) ? `WHA_CTRL_OP1 : `WHA_PPM_OP1;
        accCrm         <= (k == 0) ? `WHA_CTRL_CRM : `WHA_PPM_CRM;
        accCrn         <= (k == 5) ? 4'he : `WHA_KEY_CRN;
        accOp2         <= op2Tab[k];
        accWdata       <= wd;
        excLevel       <= el;
        el2Enabled     <= e2;
        nestedVirtFlag <= nv;
        @(posedge clock);
        accValid <= 1'b0;
        #1;
        check(rspValid, ev);
        if (ev) begin
            check({rspUndef, rspTrap}, {eu, et});
            check(rspSyndrome, et ? `WHA_TRAP_CLASS : 6'h0);
            check(rspRdata, er);
        end
        if (ok && wr) begin
            regM[k] = (k == 0) ? {48'h0, wd[15:0]} : wd;
        end
    endtask : acc

    initial begin
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        for (int k = 0; k < 5; k++) acc(k, 1'b0, `WHA_EL3, 1'b0, 1'b0, 64'h0);
        // every level, trap condition, register and direction; writes then reads
        for (int i = 0; i < 160; i++) begin
            acc(i % 5, ((i / 5) % 2) == 0, 2'((i / 10) % 4), ((i / 40) % 2) == 1,
                ((i / 80) % 2) == 1, {$random(seed), $random(seed)});
        end
        acc(5, 1'b1, `WHA_EL3, 1'b0, 1'b0, 64'hffff_ffff_ffff_ffff);
        acc(0, 1'b0, `WHA_EL3, 1'b0, 1'b0, 64'h0);
        // mixed enable and value patterns, each watched over random walks
        foreach (regM[p]) begin
            acc(0, 1'b1, `WHA_EL2, 1'b0, 1'b0,
                {48'hffff_ffff_ffff, 16'hf0f0 >> (p * 4) ^ 16'h5a3c});
            repeat (10) @(posedge clock);
        end
        // power register written and read back on consecutive edges
        @(posedge clock);
        accValid <= 1'b1;
        accWrite <= 1'b1;
        accOp1   <= `WHA_PPM_OP1;
        accCrm   <= `WHA_PPM_CRM;
        accOp2   <= `WHA_PPM_B_OP2;
        accWdata <= {$random(seed), $random(seed)};
        excLevel <= `WHA_EL3;
        @(posedge clock);
        accWrite <= 1'b0;
        regM[2] = accWdata;
        @(posedge clock);
        accValid <= 1'b0;
        #1;
        check(rspRdata, regM[2]);
        // a write offered while frozen must leave no trace
        @(posedge clock);
        clkEn    <= 1'b0;
        accValid <= 1'b1;
        accWrite <= 1'b1;
        accOp1   <= `WHA_CTRL_OP1;
        accCrm   <= `WHA_CTRL_CRM;
        accOp2   <= `WHA_CTRL_OP2;
        accWdata <= ~regM[0];
        excLevel <= `WHA_EL2;
        repeat (4) @(posedge clock);
        clkEn    <= 1'b1;
        accValid <= 1'b0;
        acc(0, 1'b0, `WHA_EL3, 1'b0, 1'b0, 64'h0);
        tallyAndFinish();
    end

    // whole run is near 410 cycles
    initial begin
        repeat (3000) @(posedge clock);
        nErrors = nErrors + 1;
        tallyAndFinish();
    end
endmodule : wha_walk_hint_control_tb
`default_nettype wire
